/* bench/nv_filter_settings_monitor.sv */
// concurrent checks on the nonvolatile settings block top ports
// assumes one clock domain with an asynchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module nv_filter_settings_monitor #(
    parameter BURN_CYCLES    = 4,
    parameter SELFTEST_STEPS = 4
) (
    // clock and reset
    input wire logic        I_CLK,
    input wire logic        I_SYS_RST,
    // register port
    input wire logic        I_REG_WR,
    input wire logic        I_REG_RD,
    input wire logic [4:0]  I_REG_ADDR,
    input wire logic [23:0] O_REG_RDATA,
    // filter side
    input wire logic [23:0] I_CONFIG_REG,
    input wire logic        O_CAL_START,
    input wire logic        O_SELFTEST_ACTIVE,
    input wire logic        O_NV_SELECT,
    input wire logic [15:0] O_NV_SETTINGS
);
    logic [3:0] since_cal_q;
    logic [3:0] since_burn_q;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    function automatic [3:0] nxt(input logic hit, input logic [3:0] q);
        nxt = hit ? 4'h0 : q + {3'h0, q != 4'hF};
    endfunction
    // saturating cycle counts since the last start and burn strobes
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            since_cal_q  <= 4'hF;
            since_burn_q <= 4'hF;
        end else begin
            since_cal_q  <= nxt(I_REG_WR && I_REG_ADDR == 5'h04, since_cal_q);
            since_burn_q <= nxt(I_REG_WR && I_REG_ADDR == 5'h0D, since_burn_q);
        end
    end
    sequence s_st_go; O_SELFTEST_ACTIVE && since_cal_q <= 4'h3; endsequence
    sequence s_st_end; ##[1:1000] !O_SELFTEST_ACTIVE; endsequence
    property p_st_start; $rose(O_SELFTEST_ACTIVE) |-> s_st_go; endproperty
    a_st_start: assert property (p_st_start) else $error("self-test began unprompted");
    property p_st_done; $rose(O_SELFTEST_ACTIVE) |-> s_st_end; endproperty
    a_st_done: assert property (p_st_done) else $error("self-test never ended");
    property p_cal_start; $rose(O_CAL_START) |-> since_cal_q <= 4'h3 ##1 !O_CAL_START; endproperty
    a_cal_start: assert property (p_cal_start) else $error("bad calibration start");
    property p_cal_excl; O_CAL_START |-> !O_SELFTEST_ACTIVE; endproperty
    a_cal_excl: assert property (p_cal_excl) else $error("calibration during self-test");
    property p_nv_sel; O_NV_SELECT == (I_CONFIG_REG[0] && O_NV_SETTINGS[13]); endproperty
    a_nv_sel: assert property (p_nv_sel) else $error("stored select wrong");
    property p_fuse_keep; (O_NV_SETTINGS & $past(O_NV_SETTINGS)) == $past(O_NV_SETTINGS); endproperty
    a_fuse_keep: assert property (p_fuse_keep) else $error("stored bit cleared");
    property p_fuse_cause; $changed(O_NV_SETTINGS) |-> since_burn_q <= 4'h5; endproperty
    a_fuse_cause: assert property (p_fuse_cause) else $error("stored word changed unprompted");
    property p_rd_nv; I_REG_RD && I_REG_ADDR == 5'h0A |=> O_REG_RDATA == {8'h00, $past(O_NV_SETTINGS)};
    endproperty
    a_rd_nv: assert property (p_rd_nv) else $error("stored word read wrong");
    property p_rd_busy; I_REG_RD && I_REG_ADDR == 5'h0F && O_SELFTEST_ACTIVE |=> O_REG_RDATA[16];
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("self-test busy not shown");
endmodule // nv_filter_settings_monitor
bind nv_filter_settings nv_filter_settings_monitor #(.BURN_CYCLES(BURN_CYCLES),
    .SELFTEST_STEPS(SELFTEST_STEPS)) mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR),
    .O_REG_RDATA(O_REG_RDATA), .I_CONFIG_REG(I_CONFIG_REG), .O_CAL_START(O_CAL_START),
    .O_SELFTEST_ACTIVE(O_SELFTEST_ACTIVE), .O_NV_SELECT(O_NV_SELECT),
    .O_NV_SETTINGS(O_NV_SETTINGS));
`default_nettype wire

/* bench/nv_filter_settings_tb.sv */
// self-checking bench for the nonvolatile settings block
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module nv_filter_settings_tb;
    localparam BURN = 4;
    localparam STEPS = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [23:0] cfg = 24'h00_0001;
    logic [3:0]  fine = 4'h0;
    logic        cal_busy = 1'b0;
    logic [7:0]  st_data = 8'h00;
    logic [31:0] seed = 32'h0000_02b7;
    wire         wr, rd, rvalid, cal_start, st_act, nv_sel;
    wire  [4:0]  addr;
    wire  [23:0] wdata, rdata;
    wire  [15:0] nv_word;
    logic [23:0] expq[$];
    logic [15:0] word, crc;
    int          err_total = 0;
    int          check_count = 0;
    int          cal_seen = 0;
    int          st_seen = 0;
    always #4 clk = ~clk;
    nv_host_model host (.i_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
        .o_reg_wdata(wdata));
    nv_filter_settings #(.BURN_CYCLES(BURN), .SELFTEST_STEPS(STEPS)) uut (.I_CLK(clk),
        .I_SYS_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .I_CONFIG_REG(cfg), .I_CAL_FINE_CODE(fine), .I_CAL_BUSY(cal_busy),
        .I_SELFTEST_DATA(st_data), .O_CAL_START(cal_start), .O_SELFTEST_ACTIVE(st_act),
        .O_NV_SELECT(nv_sel), .O_NV_SETTINGS(nv_word));
    function automatic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int k = 0; k < 8; k++) c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
        crc_byte = c;
    endfunction
    task automatic chk(input string what, input logic [23:0] exp_v, input logic [23:0] got);
        check_count++;
        if (got !== exp_v) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp_v, got);
        end
    endtask
    task automatic chk_read(input logic [23:0] exp_v, input logic [23:0] got);
        chk("read data", exp_v, got);
    endtask
    task automatic chk_pin(input string what, input logic [23:0] exp_v, input logic [23:0] got);
        chk(what, exp_v, got);
    endtask
    task automatic chk_count(input string what, input logic [23:0] exp_v,
        input logic [23:0] got);
        chk(what, exp_v, got);
    endtask
    task automatic rd_exp(input logic [4:0] a, input logic [23:0] e);
        expq.push_back(e);
        host.rd(a);
    endtask
    task automatic burn(input int b);
        host.wr(5'h0C, 24'(b));
        host.wr(5'h0D, 24'h00_0000);
        rd_exp(5'h08, {18'h0, 1'b1, cal_busy, fine});
        repeat (BURN + 2) @(negedge clk);
        rd_exp(5'h08, {18'h0, 1'b0, cal_busy, fine});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // read results come back in request order
    always @(negedge clk) begin
        if (rvalid === 1'b1) chk_read(expq.size() ? expq.pop_front() : 24'hxx_xxxx, rdata);
        if (cal_start === 1'b1) cal_seen++;
        if (st_act === 1'b1) st_seen++;
    end
    initial begin
        seed = lfsr(seed);
        fine = seed[3:0];
        cal_busy = seed[4];
        st_data = seed[12:5];
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd_exp(5'h0C, 24'h00_0000);
        rd_exp(5'h0E, 24'h00_0000);
        rd_exp(5'h0F, 24'h00_0000);
        rd_exp(5'h0D, 24'h00_0000);
        rd_exp(5'h10, 24'h00_0000);
        host.wr(5'h0C, 24'hFF_FFF5);
        rd_exp(5'h0C, 24'h00_0005);
        // strobe while programming is disabled
        host.wr(5'h0D, 24'h00_0000);
        repeat (BURN + 4) @(negedge clk);
        rd_exp(5'h0A, 24'h00_0000);
        host.wr(5'h0B, 24'h00_0001);
        seed = lfsr(seed);
        word = seed[15:0] & 16'hDFFF;
        for (int b = 0; b < 16; b++) if (word[b]) burn(b);
        chk_pin("nv select", 24'h00_0000, {23'h0, nv_sel});
        chk_pin("nv word", {8'h00, word}, {8'h00, nv_word});
        rd_exp(5'h0A, {8'h00, word});
        burn(13);
        chk_pin("nv select", 24'h00_0001, {23'h0, nv_sel});
        cfg = 24'h00_0000;
        @(negedge clk);
        chk_pin("nv select", 24'h00_0000, {23'h0, nv_sel});
        host.wr(5'h04, seed[23:0]);
        host.wr(5'h0E, 24'h00_0001);
        rd_exp(5'h0E, 24'h00_0001);
        host.wr(5'h04, seed[31:8]);
        rd_exp(5'h0F, 24'h01_0000);
        repeat (STEPS + 4) @(negedge clk);
        crc = 16'hFFFF;
        repeat (STEPS) crc = crc_byte(crc, st_data);
        rd_exp(5'h0F, {8'h00, crc});
        repeat (4) @(negedge clk);
        chk_count("start pulses", 24'd1, 24'(cal_seen));
        chk_count("self-test cycles", 24'(STEPS), 24'(st_seen));
        chk_count("reads left", 24'h00_0000, 24'(expq.size()));
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule // nv_filter_settings_tb
`default_nettype wire

/* bench/nv_host_model.sv */
// host model of the register port: one-cycle write and read strobes
// assumes callers run in step with the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module nv_host_model (
    // clock
    input  wire logic        i_clk,
    // register port toward the device
    output var  logic        o_reg_wr,
    output var  logic        o_reg_rd,
    output var  logic [4:0]  o_reg_addr,
    output var  logic [23:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 5'h1F;
        o_reg_wdata = 24'h00_0000;
    end
    // released lines show the inverse of the last value
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(negedge i_clk);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(negedge i_clk);
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a);
        @(negedge i_clk);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(negedge i_clk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
    endtask
endmodule // nv_host_model
`default_nettype wire

/* hdl/nv_filter_regs.vh */
// register offsets, field positions and timing counts for the nonvolatile settings block
// included by the settings top and its fuse array; definitions only
`ifndef NV_FILTER_REGS_VH
`define NV_FILTER_REGS_VH

// register offsets on the serial port register index
`define OFF_CONFIG          5'h01
`define OFF_CAL_STROBE      5'h04
`define OFF_CAL_STATUS      5'h08
`define OFF_NV_SETTINGS     5'h0A
`define OFF_NV_PROG_ENABLE  5'h0B
`define OFF_OTP_BIT_ADDR    5'h0C
`define OFF_OTP_STROBE      5'h0D
`define OFF_SELFTEST_EN     5'h0E
`define OFF_SELFTEST_RESULT 5'h0F

// nonvolatile settings word fields
`define NV_FINE_LSB         0
`define NV_FINE_MSB         3
`define NV_COARSE_LSB       4
`define NV_COARSE_MSB       6
`define NV_GAIN_BIT         7
`define NV_BYPASS_BIT       8
`define NV_AMP_BIAS_LSB     9
`define NV_AMP_BIAS_MSB     10
`define NV_DRV_BIAS_LSB     11
`define NV_DRV_BIAS_MSB     12
`define NV_VALID_BIT        13
`define NV_COARSE3_BIT      14
`define NV_ZIN_BIT          15

// other fields
`define CFG_NV_SELECT_BIT   0
`define STATUS_CAL_BUSY_BIT 4
`define STATUS_NV_BUSY_BIT  5
`define RESULT_BUSY_BIT     16

// reset values and crc polynomial
`define RST_BIT_ADDR        4'h0
`define RST_SIGNATURE       16'h0000
`define RST_CRC_SEED        16'hFFFF
`define CRC_POLY            16'h1021

// timing
`define FUSE_BURN_NS        10000
`define CLK_PERIOD_NS       8
`define FUSE_BURN_CYCLES    ((`FUSE_BURN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELFTEST_STEPS      256

`endif

/* hdl/nv_filter_settings.v */
// nonvolatile settings readback, fuse programming and rc self-test control
// assumes a host register port synchronous to I_CLK, one-cycle write/read strobes
`timescale 1ns/100ps
`default_nettype none
`include "nv_filter_regs.vh"

// Operation
// - nv word [3:0] shows stored fine code
// - nv word [6:4] shows stored coarse low bits
// - nv word bit 14 shows coarse MSB
// - nv word bit 15 shows input impedance
// - bias copies at [10:9] and [12:11]
// - gain bit 7, bypass bit 8
// - stored settings used only when valid flag
// - valid clear forces config bit 0 low
// - 4-bit fuse address register at 0Ch
// - write to 0Dh burns addressed fuse
// - 0Eh bit 0 enables self-test mode
// - 0Fh [15:0] reports self-test signature
// - 0Fh bit 16 high until self-test done
// - write to 04h starts calibration or self-test
// - status bit 5 high while burning
module nv_filter_settings #(
    parameter BURN_CYCLES    = `FUSE_BURN_CYCLES,
    parameter SELFTEST_STEPS = `SELFTEST_STEPS
) (
    // clock and reset
    input  wire        I_CLK,
    input  wire        I_SYS_RST,
    // register port
    input  wire        I_REG_WR,
    input  wire        I_REG_RD,
    input  wire [4:0]  I_REG_ADDR,
    input  wire [23:0] I_REG_WDATA,
    output reg  [23:0] O_REG_RDATA,
    output reg         O_REG_RVALID,
    // live configuration from the surrounding register file
    input  wire [23:0] I_CONFIG_REG,
    input  wire [3:0]  I_CAL_FINE_CODE,
    input  wire        I_CAL_BUSY,
    // self-test data from the calibration engine
    input  wire [7:0]  I_SELFTEST_DATA,
    // outputs to the filter core
    output reg         O_CAL_START,
    output reg         O_SELFTEST_ACTIVE,
    output wire        O_NV_SELECT,
    output wire [15:0] O_NV_SETTINGS
);

    localparam ST_IDLE = 3'b001;
    localparam ST_BURN = 3'b010;
    localparam ST_TEST = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg         prog_en_q;
    reg  [3:0]  bit_addr_q;
    reg         selftest_en_q;
    reg  [15:0] crc_q;
    reg  [15:0] crc_d;
    reg  [15:0] signature_q;
    reg         st_busy_q;
    reg  [31:0] count_q;
    reg  [31:0] count_d;
    reg         burn_q;
    reg         cal_start_d;
    reg  [23:0] rdata_d;
    wire [15:0] nv_word;
    wire        nv_valid;
    wire [3:0]  nv_fine_code;
    wire [2:0]  nv_coarse_low;
    wire        nv_high_gain_select;
    wire        nv_bypass_sel;
    wire [1:0]  nv_amp_bias;
    wire [1:0]  nv_drv_bias;
    wire        nv_coarse_msb;
    wire        nv_input_impedance_sel;
    wire        wr_strobe;
    wire        wr_cal;
    wire        wr_prog_en;
    wire        wr_bit_addr;
    wire        wr_st_en;
    wire        burn_go;
    wire        test_go;
    wire        test_done;
    wire        nv_write_in_progress;
    wire        selftest_running;
    integer     k;

    // write decodes, one per writable register or strobe offset
    assign wr_strobe   = I_REG_WR && (I_REG_ADDR == `OFF_OTP_STROBE);
    assign wr_cal      = I_REG_WR && (I_REG_ADDR == `OFF_CAL_STROBE);
    assign wr_prog_en  = I_REG_WR && (I_REG_ADDR == `OFF_NV_PROG_ENABLE);
    assign wr_bit_addr = I_REG_WR && (I_REG_ADDR == `OFF_OTP_BIT_ADDR);
    assign wr_st_en    = I_REG_WR && (I_REG_ADDR == `OFF_SELFTEST_EN);

    nv_fuse_array #(
        .WIDTH (16),
        .AW    (4)
    ) u_fuse (
        .i_clk       (I_CLK),
        .i_rst       (I_SYS_RST),
        .i_burn      (burn_q),
        .i_burn_addr (bit_addr_q),
        .o_word      (nv_word)
    );

    // field layout is the fuse layout, so each field passes through in place
    assign nv_fine_code           = nv_word[`NV_FINE_MSB:`NV_FINE_LSB];
    assign nv_coarse_low          = nv_word[`NV_COARSE_MSB:`NV_COARSE_LSB];
    assign nv_high_gain_select    = nv_word[`NV_GAIN_BIT];
    assign nv_bypass_sel          = nv_word[`NV_BYPASS_BIT];
    assign nv_amp_bias            = nv_word[`NV_AMP_BIAS_MSB:`NV_AMP_BIAS_LSB];
    assign nv_drv_bias            = nv_word[`NV_DRV_BIAS_MSB:`NV_DRV_BIAS_LSB];
    assign nv_valid               = nv_word[`NV_VALID_BIT];
    assign nv_coarse_msb          = nv_word[`NV_COARSE3_BIT];
    assign nv_input_impedance_sel = nv_word[`NV_ZIN_BIT];

    assign O_NV_SETTINGS = {
        nv_input_impedance_sel,
        nv_coarse_msb,
        nv_valid,
        nv_drv_bias,
        nv_amp_bias,
        nv_bypass_sel,
        nv_high_gain_select,
        nv_coarse_low,
        nv_fine_code
    };

    // stored settings only take effect with the valid flag burnt in
    assign O_NV_SELECT = I_CONFIG_REG[`CFG_NV_SELECT_BIT] & nv_valid;

    // programming enable: fuse burn strobes at 0Dh are ignored until this is set
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            prog_en_q <= 1'b0;
        end else if (wr_prog_en) begin
            prog_en_q <= I_REG_WDATA[0];
        end
    end

    // fuse bit address for the next strobe
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            bit_addr_q <= `RST_BIT_ADDR;
        end else if (wr_bit_addr) begin
            bit_addr_q <= I_REG_WDATA[3:0];
        end
    end

    // self-test mode enable, steers the next calibration strobe
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            selftest_en_q <= 1'b0;
        end else if (wr_st_en) begin
            selftest_en_q <= I_REG_WDATA[0];
        end
    end

    // sequencer: fuse burn, self-test, or pass-through of calibration start
    always @* begin
        state_d     = state_q;
        count_d     = count_q;
        cal_start_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                count_d = 32'd0;
                if (wr_strobe && prog_en_q) begin
                    state_d = ST_BURN;
                end else if (wr_cal && selftest_en_q) begin
                    state_d = ST_TEST;
                end else if (wr_cal) begin
                    cal_start_d = 1'b1;
                end
            end
            ST_BURN: begin
                if (count_q >= BURN_CYCLES - 1) begin
                    state_d = ST_IDLE;
                end else begin
                    count_d = count_q + 32'd1;
                end
            end
            ST_TEST: begin
                if (count_q >= SELFTEST_STEPS - 1) begin
                    state_d = ST_IDLE;
                end else begin
                    count_d = count_q + 32'd1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // crc-16 over the engine's self-test bytes, msb first
    always @* begin
        crc_d = crc_q;
        for (k = 7; k >= 0; k = k - 1) begin
            if (crc_d[15] ^ I_SELFTEST_DATA[k]) begin
                crc_d = {crc_d[14:0], 1'b0} ^ `CRC_POLY;
            end else begin
                crc_d = {crc_d[14:0], 1'b0};
            end
        end
    end

    // sequencer events, decoded once for the registers below
    assign burn_go   = (state_q == ST_IDLE) && (state_d == ST_BURN);
    assign test_go   = (state_q == ST_IDLE) && (state_d == ST_TEST);
    assign test_done = (state_q == ST_TEST) && (state_d == ST_IDLE);

    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q <= ST_IDLE;
            count_q <= 32'd0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // one-cycle burn pulse on entry to the burn state
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            burn_q            <= 1'b0;
            O_CAL_START       <= 1'b0;
            O_SELFTEST_ACTIVE <= 1'b0;
        end else begin
            burn_q            <= burn_go;
            O_CAL_START       <= cal_start_d;
            O_SELFTEST_ACTIVE <= (state_d == ST_TEST);
        end
    end

    // signature is only replaced at the end, so a read mid-test never shows a partial crc
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            crc_q       <= `RST_CRC_SEED;
            signature_q <= `RST_SIGNATURE;
            st_busy_q   <= 1'b0;
        end else if (test_go) begin
            crc_q     <= `RST_CRC_SEED;
            st_busy_q <= 1'b1;
        end else if (state_q == ST_TEST) begin
            crc_q <= crc_d;
            if (test_done) begin
                signature_q <= crc_d;
                st_busy_q   <= 1'b0;
            end
        end
    end

    // busy flags as the host reads them
    assign nv_write_in_progress = (state_q == ST_BURN);
    assign selftest_running     = st_busy_q;

    // read mux; unmapped and write-only offsets read zero
    always @* begin
        rdata_d = 24'h00_0000;
        case (I_REG_ADDR)
            `OFF_CAL_STATUS: begin
                rdata_d[3:0]                 = I_CAL_FINE_CODE;
                rdata_d[`STATUS_CAL_BUSY_BIT] = I_CAL_BUSY;
                rdata_d[`STATUS_NV_BUSY_BIT]  = nv_write_in_progress;
            end
            `OFF_NV_SETTINGS: begin
                rdata_d[15:0] = O_NV_SETTINGS;
            end
            `OFF_NV_PROG_ENABLE: begin
                rdata_d[0] = prog_en_q;
            end
            `OFF_OTP_BIT_ADDR: begin
                rdata_d[3:0] = bit_addr_q;
            end
            `OFF_SELFTEST_EN: begin
                rdata_d[0] = selftest_en_q;
            end
            `OFF_SELFTEST_RESULT: begin
                rdata_d[15:0]             = signature_q;
                rdata_d[`RESULT_BUSY_BIT] = selftest_running;
            end
            default: begin
                rdata_d = 24'h00_0000;
            end
        endcase
    end

    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_REG_RDATA  <= 24'h00_0000;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= rdata_d;
            end
        end
    end

endmodule // nv_filter_settings

`default_nettype wire

/* hdl/nv_fuse_array.v */
// one-time-programmable fuse word: bits only ever go from 0 to 1
// assumes a single clock; a burn pulse sets the addressed bit, readout is registered
`timescale 1ns/100ps
`default_nettype none
`include "nv_filter_regs.vh"

module nv_fuse_array #(
    parameter WIDTH  = 16,
    parameter AW     = 4
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_rst,
    // burn port
    input  wire             i_burn,
    input  wire [AW-1:0]    i_burn_addr,
    // readout
    output reg  [WIDTH-1:0] o_word
);

    wire [WIDTH-1:0] burn_hit;
    reg  [WIDTH-1:0] fuse_q;
    genvar g;

    // one address match per fuse bit
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_fuse
            localparam [AW-1:0] BIT_ADDR = g;
            assign burn_hit[g] = i_burn && (i_burn_addr == BIT_ADDR);
        end
    endgenerate

    // fuse contents model a blank part after power-up; a burn never clears a bit
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fuse_q <= {WIDTH{1'b0}};
        end else begin
            fuse_q <= fuse_q | burn_hit;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_word <= {WIDTH{1'b0}};
        end else begin
            o_word <= fuse_q;
        end
    end

endmodule // nv_fuse_array

`default_nettype wire
